// ---- logic/eap_position_core.sv ----
`timescale 1ns/100ps
module eap_position_core
    import eap_pkg::*;
#(
    parameter int STORE_CYCLES = EAP_STORE_CYCLES,
    parameter int MS_CYCLES = EAP_MS_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] par_addr_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [31:0] par_wdata_i,
    output logic [31:0] par_rdata_o,
    output logic par_ack_o,
    output logic par_err_o,
    input wire logic enc_multiturn_i,
    input wire logic [25:0] enc_pos_i,
    input wire logic enc_valid_i,
    output logic enc_req_o,
    input wire logic motor_standstill_i,
    input wire logic [25:0] nv_offset_i,
    output logic [25:0] nv_offset_o,
    output logic nv_store_o,
    output logic store_busy_o,
    output logic signed [31:0] act_pos_o,
    output logic enc_index_o,
    output logic emu_index_o,
    output logic [15:0] warning_active_word_o,
    output logic [15:0] warning_latched_word_o,
    input wire logic warn_clear_i,
    input wire logic brake_on_i,
    input wire logic [15:0] brake_power_i,
    input wire logic fault_reset_i,
    output logic brake_fault_o,
    output logic power_stage_disable_o
);
    eap_state_t state_reg;
    logic pos_valid;
    logic [25:0] offset_reg;
    logic [25:0] raw_prev_reg;
    logic [25:0] abs_mod;
    logic [31:0] abs_pos;
    logic [31:0] set_reg;
    logic signed [31:0] act_reg;
    logic [31:0] store_cnt_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic err_reg;
    logic warn_latch_reg;
    logic [15:0] res_sel_reg;
    logic [15:0] res_ton_reg;
    logic [15:0] res_pwr_reg;
    logic [15:0] res_val_reg;
    logic enc_index_reg;
    logic emu_index_reg;
    logic nv_store_reg;
    logic [25:0] nv_offset_reg;
    logic wr_ok;
    logic set_ok;

    // modular wrap of a 26-bit quantity to the encoder stroke
    function automatic logic [25:0] stroke_wrap(input logic [25:0] v, input logic mt);
        stroke_wrap = mt ? v : {12'h000, v[EAP_ST_BITS-1:0]};
    endfunction

    function automatic logic in_range16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range16 = (v[31:16] == 16'h0000) && (v[15:0] >= lo) && (v[15:0] <= hi);
    endfunction

    // start-up sequence: fetch the stored offset and one absolute reading
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= EAP_ST_REQ;
        end else begin
            case (state_reg)
                EAP_ST_REQ: state_reg <= EAP_ST_WAIT;
                EAP_ST_WAIT: if (enc_valid_i) state_reg <= EAP_ST_RUN;
                default: state_reg <= EAP_ST_RUN;
            endcase
        end
    end
    assign pos_valid = (state_reg == EAP_ST_RUN);
    assign enc_req_o = (state_reg == EAP_ST_REQ);

    // the offset takes effect only when captured here after power-on
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            offset_reg <= '0;
        end else if (state_reg == EAP_ST_REQ) begin
            offset_reg <= nv_offset_i;
        end
    end

    assign abs_mod = stroke_wrap(enc_pos_i + offset_reg, enc_multiturn_i);
    assign abs_pos = {6'h00, abs_mod};

    // actual position: abs at start, then unwrapped deltas, may go negative
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_reg <= '0;
            raw_prev_reg <= '0;
        end else if (state_reg == EAP_ST_WAIT && enc_valid_i) begin
            act_reg <= signed'(abs_pos);
            raw_prev_reg <= enc_pos_i;
        end else if (pos_valid) begin
            raw_prev_reg <= enc_pos_i;
            if (enc_multiturn_i) begin
                act_reg <= act_reg + 32'(signed'(enc_pos_i - raw_prev_reg));
            end else begin
                act_reg <= act_reg + 32'(signed'(enc_pos_i[EAP_ST_BITS-1:0] - raw_prev_reg[EAP_ST_BITS-1:0]));
            end
        end
    end
    assign act_pos_o = act_reg;

    // index fires where the offset-corrected position crosses a revolution
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_index_reg <= 1'b0;
            emu_index_reg <= 1'b0;
        end else begin
            enc_index_reg <= pos_valid && (act_pos_o[31:EAP_ST_BITS] != act_reg_next_hi());
            emu_index_reg <= pos_valid && (act_pos_o[31:EAP_ST_BITS] != act_reg_next_hi());
        end
    end
    function automatic logic [17:0] act_reg_next_hi();
        logic [31:0] nxt;
        nxt = enc_multiturn_i ? 32'(signed'(enc_pos_i - raw_prev_reg))
                              : 32'(signed'(enc_pos_i[EAP_ST_BITS-1:0] - raw_prev_reg[EAP_ST_BITS-1:0]));
        nxt = 32'(act_reg) + nxt;
        act_reg_next_hi = nxt[31:EAP_ST_BITS];
    endfunction
    assign enc_index_o = enc_index_reg;
    assign emu_index_o = emu_index_reg;

    // warnings: active follows validity, latched is sticky with set winning
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_latch_reg <= 1'b1;
        end else if (!pos_valid) begin
            warn_latch_reg <= 1'b1;
        end else if (warn_clear_i) begin
            warn_latch_reg <= 1'b0;
        end
    end
    always_comb begin
        warning_active_word_o = '0;
        warning_latched_word_o = '0;
        warning_active_word_o[EAP_WARN_ABS_BIT] = !pos_valid;
        warning_latched_word_o[EAP_WARN_ABS_BIT] = warn_latch_reg;
    end

    // parameter access; refused writes answer with an error and change nothing
    assign set_ok = pos_valid && motor_standstill_i && (par_wdata_i <= EAP_SET_MAX)
                    && (enc_multiturn_i || par_wdata_i <= EAP_REV_UNITS);
    always_comb begin
        wr_ok = 1'b0;
        if (par_addr_i == EAP_ADDR_POS_SET) begin
            wr_ok = set_ok;
        end else if (par_addr_i == EAP_ADDR_RES_SEL) begin
            wr_ok = in_range16(par_wdata_i, 16'h0000, EAP_SEL_MAX);
        end else if (par_addr_i == EAP_ADDR_RES_TON) begin
            wr_ok = in_range16(par_wdata_i, EAP_TON_MIN, EAP_TON_MAX);
        end else if (par_addr_i == EAP_ADDR_RES_PWR || par_addr_i == EAP_ADDR_RES_VAL) begin
            wr_ok = in_range16(par_wdata_i, EAP_PR_MIN, EAP_PR_MAX);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            set_reg <= '0;
            res_sel_reg <= EAP_SEL_RST;
            res_ton_reg <= EAP_TON_RST;
            res_pwr_reg <= EAP_PWR_RST;
            res_val_reg <= EAP_VAL_RST;
        end else if (par_wr_i && wr_ok) begin
            if (par_addr_i == EAP_ADDR_POS_SET) begin
                set_reg <= par_wdata_i;
            end else if (par_addr_i == EAP_ADDR_RES_SEL) begin
                res_sel_reg <= par_wdata_i[15:0];
            end else if (par_addr_i == EAP_ADDR_RES_TON) begin
                res_ton_reg <= par_wdata_i[15:0];
            end else if (par_addr_i == EAP_ADDR_RES_PWR) begin
                res_pwr_reg <= par_wdata_i[15:0];
            end else begin
                res_val_reg <= par_wdata_i[15:0];
            end
        end
    end

    // new offset = requested position minus current raw reading
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_store_reg <= 1'b0;
            nv_offset_reg <= '0;
        end else begin
            nv_store_reg <= par_wr_i && wr_ok && (par_addr_i == EAP_ADDR_POS_SET);
            if (par_wr_i && wr_ok && par_addr_i == EAP_ADDR_POS_SET) begin
                nv_offset_reg <= stroke_wrap(par_wdata_i[25:0] - enc_pos_i, enc_multiturn_i);
            end
        end
    end
    assign nv_store_o = nv_store_reg;
    assign nv_offset_o = nv_offset_reg;

    // busy window the host must respect before removing power
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            store_cnt_reg <= '0;
        end else if (nv_store_reg) begin
            store_cnt_reg <= 32'(STORE_CYCLES);
        end else if (store_cnt_reg != 32'h0) begin
            store_cnt_reg <= store_cnt_reg - 32'h1;
        end
    end
    assign store_busy_o = (store_cnt_reg != 32'h0);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= par_rd_i || par_wr_i;
            err_reg <= 1'b0;
            rdata_reg <= '0;
            if (par_rd_i) begin
                if (par_addr_i == EAP_ADDR_ABS_POS) begin
                    rdata_reg <= pos_valid ? abs_pos : 32'h0;
                end else if (par_addr_i == EAP_ADDR_POS_SET) begin
                    rdata_reg <= set_reg;
                end else if (par_addr_i == EAP_ADDR_RES_SEL) begin
                    rdata_reg <= {16'h0000, res_sel_reg};
                end else if (par_addr_i == EAP_ADDR_RES_TON) begin
                    rdata_reg <= {16'h0000, res_ton_reg};
                end else if (par_addr_i == EAP_ADDR_RES_PWR) begin
                    rdata_reg <= {16'h0000, res_pwr_reg};
                end else if (par_addr_i == EAP_ADDR_RES_VAL) begin
                    rdata_reg <= {16'h0000, res_val_reg};
                end else begin
                    err_reg <= 1'b1;
                end
            end else if (par_wr_i) begin
                err_reg <= !wr_ok; // readback address has no write path
            end
        end
    end
    assign par_rdata_o = rdata_reg;
    assign par_ack_o = ack_reg;
    assign par_err_o = err_reg;

    eap_brake_monitor #(
        .MS_CYCLES(MS_CYCLES)
    ) u_brake (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ext_select_i(res_sel_reg[0]),
        .ext_power_i(res_pwr_reg),
        .ext_ton_i(res_ton_reg),
        .brake_on_i(brake_on_i),
        .brake_power_i(brake_power_i),
        .fault_reset_i(fault_reset_i),
        .brake_fault_o(brake_fault_o)
    );
    assign power_stage_disable_o = brake_fault_o;

    sequence s_set_write;
        par_wr_i && (par_addr_i == EAP_ADDR_POS_SET) && set_ok;
    endsequence
    sequence s_store_then_busy;
        nv_store_o ##1 store_busy_o;
    endsequence

    a_moving_write_refused: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        par_wr_i && par_addr_i == EAP_ADDR_POS_SET && !motor_standstill_i |=> par_err_o && $stable(set_reg))
        else $error("set value accepted while moving");
    a_set_range_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        set_reg <= EAP_SET_MAX) else $error("set value above range");
    a_single_turn_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        par_wr_i && par_addr_i == EAP_ADDR_POS_SET && !enc_multiturn_i && par_wdata_i > EAP_REV_UNITS
        |=> par_err_o) else $error("singleturn set beyond one revolution accepted");
    a_store_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_set_write |=> s_store_then_busy) else $error("set write not stored or busy missing");
    a_warn_while_invalid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pos_valid |-> warning_active_word_o[EAP_WARN_ABS_BIT] && warning_latched_word_o[EAP_WARN_ABS_BIT])
        else $error("warning bit missing while position invalid");
    a_readback_invalid_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        par_rd_i && par_addr_i == EAP_ADDR_ABS_POS && !pos_valid |=> par_ack_o && par_rdata_o == 32'h0)
        else $error("position reported before encoder read");
    a_readback_is_abs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        par_rd_i && par_addr_i == EAP_ADDR_ABS_POS && pos_valid |=> par_rdata_o == $past(abs_pos))
        else $error("readback differs from offset position");
    a_stroke_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !enc_multiturn_i |-> abs_pos < EAP_REV_UNITS) else $error("singleturn position beyond revolution");
    a_offset_from_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_set_write |=> nv_offset_o == stroke_wrap($past(par_wdata_i[25:0]) - $past(enc_pos_i), $past(enc_multiturn_i)))
        else $error("stored offset wrong");
    a_index_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (enc_index_o || emu_index_o) |-> enc_index_o && emu_index_o
        && act_pos_o[31:EAP_ST_BITS] != $past(act_pos_o[31:EAP_ST_BITS]))
        else $error("index pulse without revolution crossing");
    a_trip_disables: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        brake_fault_o && !fault_reset_i |=> brake_fault_o && power_stage_disable_o)
        else $error("brake trip released without fault reset");
endmodule

// ---- inc/eap_pkg.sv ----
package eap_pkg;
    // parameter addresses as seen on the fieldbus
    localparam logic [15:0] EAP_ADDR_POS_SET = 16'h052c;
    localparam logic [15:0] EAP_ADDR_ABS_POS = 16'h1e1e;
    localparam logic [15:0] EAP_ADDR_RES_SEL = 16'h0512;
    localparam logic [15:0] EAP_ADDR_RES_TON = 16'h0522;
    localparam logic [15:0] EAP_ADDR_RES_PWR = 16'h0524;
    localparam logic [15:0] EAP_ADDR_RES_VAL = 16'h0526;

    // position geometry in user units, and the position warning bit
    localparam int EAP_ST_BITS = 14;
    localparam int EAP_MT_BITS = 26;
    localparam logic [31:0] EAP_REV_UNITS = 32'h0000_4000;
    localparam logic [31:0] EAP_SET_MAX = 32'h7fff_ffff;
    localparam int EAP_WARN_ABS_BIT = 13;

    // braking resistor parameter limits and defaults
    localparam logic [15:0] EAP_SEL_MAX = 16'h0001;
    localparam logic [15:0] EAP_TON_MIN = 16'h0001;
    localparam logic [15:0] EAP_TON_MAX = 16'h7530;
    localparam logic [15:0] EAP_PR_MIN = 16'h0001;
    localparam logic [15:0] EAP_PR_MAX = 16'h7fff;
    localparam logic [15:0] EAP_SEL_RST = 16'h0000;
    localparam logic [15:0] EAP_TON_RST = 16'h0001;
    localparam logic [15:0] EAP_PWR_RST = 16'h000a;
    localparam logic [15:0] EAP_VAL_RST = 16'h2710;

    // timing
    localparam int EAP_CLK_HZ = 100_000_000;
    localparam int EAP_STORE_WAIT_MS = 1000;
    localparam int EAP_MS_CYCLES = EAP_CLK_HZ / 1000;
    localparam int EAP_STORE_CYCLES = EAP_MS_CYCLES * EAP_STORE_WAIT_MS;

    typedef enum logic [1:0] {
        EAP_ST_REQ,
        EAP_ST_WAIT,
        EAP_ST_RUN
    } eap_state_t;
endpackage

// ---- logic/eap_brake_monitor.sv ----
`timescale 1ns/100ps
module eap_brake_monitor
    import eap_pkg::*;
#(
    parameter int MS_CYCLES = EAP_MS_CYCLES,
    parameter logic [15:0] INT_POWER_W = 16'h0028,
    parameter logic [15:0] INT_TON_MS = 16'h0005
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ext_select_i,
    input wire logic [15:0] ext_power_i,
    input wire logic [15:0] ext_ton_i,
    input wire logic brake_on_i,
    input wire logic [15:0] brake_power_i,
    input wire logic fault_reset_i,
    output logic brake_fault_o
);
    logic [31:0] ms_cnt_reg;
    logic ms_tick;
    logic [15:0] on_ms_reg;
    logic [15:0] power_limit;
    logic [15:0] ton_limit;
    logic overload;
    logic fault_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ms_cnt_reg <= '0;
        end else if (!brake_on_i || ms_tick) begin
            ms_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end
    assign ms_tick = brake_on_i && (ms_cnt_reg == 32'(MS_CYCLES - 1));

    // continuous switch-in time of the chopper, in milliseconds
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_ms_reg <= '0;
        end else if (!brake_on_i) begin
            on_ms_reg <= '0;
        end else if (ms_tick && on_ms_reg != 16'hffff) begin
            on_ms_reg <= on_ms_reg + 16'h1;
        end
    end

    assign power_limit = ext_select_i ? ext_power_i : INT_POWER_W;
    assign ton_limit = ext_select_i ? ext_ton_i : INT_TON_MS;
    assign overload = (brake_power_i > power_limit) || (brake_on_i && on_ms_reg >= ton_limit);

    // trip is sticky; a reset attempt during overload is ignored
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_reg <= 1'b0;
        end else if (overload) begin
            fault_reg <= 1'b1;
        end else if (fault_reset_i) begin
            fault_reg <= 1'b0;
        end
    end
    assign brake_fault_o = fault_reg;

    a_overload_trips: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        overload |=> brake_fault_o) else $error("overload did not trip power stage");
endmodule

// ---- sim/eap_enc_model.sv ----
`timescale 1ns/100ps
module eap_enc_model #(
    parameter int DELAY = 12
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic multiturn_i,
    input wire logic [25:0] raw_i,
    output logic multiturn_o,
    output logic [25:0] pos_o,
    output logic valid_o
);
    int wait_cnt;
    // known start value so the not-ready pattern never carries unknowns
    logic [25:0] last_pos = '0;

    // a slow sensor: the reading is only ready DELAY cycles after the request
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 0;
        end else if (!req_i && wait_cnt < DELAY) begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    always @(posedge ref_clk_i) begin
        last_pos <= pos_o;
    end

    assign valid_o = (wait_cnt == DELAY);
    assign multiturn_o = multiturn_i;
    // no usable reading before valid: toggle the bits so stale data never looks plausible
    assign pos_o = !valid_o ? ~last_pos : (multiturn_i ? raw_i : {12'h000, raw_i[13:0]});
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import eap_pkg::*;
    localparam int STORE_N = 20;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] par_addr_i = 16'h0000;
    logic par_wr_i = 1'b0;
    logic par_rd_i = 1'b0;
    logic [31:0] par_wdata_i = 32'h0000_0000;
    logic [31:0] par_rdata_o;
    logic par_ack_o, par_err_o, enc_multiturn_i, enc_valid_i, enc_req_o, nv_store_o, store_busy_o;
    logic [25:0] enc_pos_i, nv_offset_o;
    logic [25:0] nv_offset_i = 26'h0000000;
    logic [25:0] raw_pos = 26'h0000064;
    logic multiturn = 1'b0;
    logic motor_standstill_i = 1'b0;
    logic warn_clear_i = 1'b0;
    logic brake_on_i = 1'b0;
    logic [15:0] brake_power_i = 16'h0000;
    logic fault_reset_i = 1'b0;
    logic signed [31:0] act_pos_o;
    logic enc_index_o, emu_index_o, brake_fault_o, power_stage_disable_o;
    logic [15:0] warning_active_word_o, warning_latched_word_o;
    int errors = 0;
    int samples_checked = 0;
    int enc_idx_n = 0;
    int emu_idx_n = 0;

    eap_position_core #(.STORE_CYCLES(STORE_N), .MS_CYCLES(4)) i_eap_position_core (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .par_addr_i(par_addr_i), .par_wr_i(par_wr_i),
        .par_rd_i(par_rd_i), .par_wdata_i(par_wdata_i), .par_rdata_o(par_rdata_o), .par_ack_o(par_ack_o),
        .par_err_o(par_err_o), .enc_multiturn_i(enc_multiturn_i), .enc_pos_i(enc_pos_i),
        .enc_valid_i(enc_valid_i), .enc_req_o(enc_req_o), .motor_standstill_i(motor_standstill_i),
        .nv_offset_i(nv_offset_i), .nv_offset_o(nv_offset_o), .nv_store_o(nv_store_o),
        .store_busy_o(store_busy_o), .act_pos_o(act_pos_o), .enc_index_o(enc_index_o),
        .emu_index_o(emu_index_o), .warning_active_word_o(warning_active_word_o),
        .warning_latched_word_o(warning_latched_word_o), .warn_clear_i(warn_clear_i),
        .brake_on_i(brake_on_i), .brake_power_i(brake_power_i), .fault_reset_i(fault_reset_i),
        .brake_fault_o(brake_fault_o), .power_stage_disable_o(power_stage_disable_o));

    eap_enc_model i_eap_enc_model (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(enc_req_o), .multiturn_i(multiturn),
        .raw_i(raw_pos), .multiturn_o(enc_multiturn_i), .pos_o(enc_pos_i), .valid_o(enc_valid_i));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // stands in for the non-volatile store that survives a power cycle
    always @(posedge ref_clk_i) begin
        if (nv_store_o === 1'b1) nv_offset_i <= nv_offset_o;
        if (enc_index_o === 1'b1) enc_idx_n++;
        if (emu_index_o === 1'b1) emu_idx_n++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge ref_clk_i);
        par_wr_i <= w;
        par_rd_i <= !w;
        par_addr_i <= a;
        par_wdata_i <= d;
        @(posedge ref_clk_i);
        par_wr_i <= 1'b0;
        par_rd_i <= 1'b0;
        #1;
        check({31'h0, par_ack_o}, 32'h1);
        q = par_rdata_o;
        e = par_err_o;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, q, e);
        check({31'h0, e}, {31'h0, ee});
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        check({31'h0, e}, {31'h0, ee});
        if (!ee) check(q, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // power is only removed once the store has finished
    task automatic repower();
        int n;
        wait_store();
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, enc_req_o}, 32'h1);
        rst_i <= 1'b0;
        n = 0;
        while (warning_active_word_o[EAP_WARN_ABS_BIT] !== 1'b0 && n < 60) begin
            @(posedge ref_clk_i);
            n++;
        end
        #1;
        check({16'h0, warning_active_word_o}, 32'h0);
    endtask

    task automatic wait_store();
        int n;
        // busy only rises one cycle after the store pulse
        cycles(1);
        n = 0;
        while (store_busy_o !== 1'b0 && n < STORE_N + 5) begin
            @(posedge ref_clk_i);
            n++;
        end
        #1;
        check({31'h0, store_busy_o}, 32'h0);
    endtask

    task automatic move_to(input logic [25:0] target);
        logic [25:0] p;
        p = raw_pos;
        while (p != target) begin
            @(posedge ref_clk_i);
            p = (target > p) ? p + 26'h1 : p - 26'h1;
            raw_pos <= p;
        end
        cycles(4);
    endtask

    task automatic t_startup();
        cycles(1);
        check({16'h0, warning_active_word_o}, 32'h2000);
        check({16'h0, warning_latched_word_o}, 32'h2000);
        rd(EAP_ADDR_ABS_POS, 32'h0, 1'b0);
        motor_standstill_i <= 1'b1;
        wr(EAP_ADDR_POS_SET, 32'h5, 1'b1);
        repower();
        check(act_pos_o, 32'h64);
        rd(EAP_ADDR_ABS_POS, 32'h64, 1'b0);
        check({16'h0, warning_latched_word_o}, 32'h2000);
        warn_clear_i <= 1'b1;
        @(posedge ref_clk_i);
        warn_clear_i <= 1'b0;
        cycles(1);
        check({16'h0, warning_latched_word_o}, 32'h0);
        wr(EAP_ADDR_ABS_POS, 32'h1, 1'b1);
        rd(16'h0100, 32'h0, 1'b1);
    endtask

    task automatic t_single();
        // direction is never inverted here, so set writes already follow it
        motor_standstill_i <= 1'b0;
        wr(EAP_ADDR_POS_SET, 32'h0, 1'b1);
        motor_standstill_i <= 1'b1;
        wr(EAP_ADDR_POS_SET, 32'h4001, 1'b1);
        wr(EAP_ADDR_POS_SET, EAP_REV_UNITS, 1'b0);
        wait_store();
        wr(EAP_ADDR_POS_SET, 32'h0, 1'b0);
        check({31'h0, nv_store_o}, 32'h1);
        check({18'h0, nv_offset_o[13:0]}, 32'h3f9c);
        cycles(1);
        check({31'h0, store_busy_o}, 32'h1);
        check(act_pos_o, 32'h64);
        repower();
        rd(EAP_ADDR_ABS_POS, 32'h0, 1'b0);
        check(act_pos_o, 32'h0);
    endtask

    task automatic t_multi();
        multiturn <= 1'b1;
        raw_pos <= 26'h00001f4;
        repower();
        wr(EAP_ADDR_POS_SET, 32'h8000_0000, 1'b1);
        wr(EAP_ADDR_POS_SET, 32'h3ffc, 1'b0);
        check({6'h0, nv_offset_o}, 32'h3e08);
        rd(EAP_ADDR_POS_SET, 32'h3ffc, 1'b0);
        repower();
        rd(EAP_ADDR_ABS_POS, 32'h3ffc, 1'b0);
        enc_idx_n = 0;
        emu_idx_n = 0;
        move_to(26'h00001fc);
        check(act_pos_o, 32'h4004);
        check(enc_idx_n, 32'h1);
        check(emu_idx_n, 32'h1);
        // a small positive value near zero lets travel run below zero, so the reading wraps at 26 bits
        wr(EAP_ADDR_POS_SET, 32'h2, 1'b0);
        repower();
        rd(EAP_ADDR_ABS_POS, 32'h2, 1'b0);
        move_to(26'h00001f7);
        check(act_pos_o, 32'hffff_fffd);
        repower();
        check(act_pos_o, 32'h03ff_fffd);
    endtask

    task automatic t_brake();
        rd(EAP_ADDR_RES_SEL, 32'h0, 1'b0);
        rd(EAP_ADDR_RES_TON, 32'h1, 1'b0);
        wr(EAP_ADDR_RES_SEL, 32'h2, 1'b1);
        wr(EAP_ADDR_RES_TON, 32'h0, 1'b1);
        wr(EAP_ADDR_RES_TON, 32'h7531, 1'b1);
        wr(EAP_ADDR_RES_TON, 32'h7530, 1'b0);
        rd(EAP_ADDR_RES_TON, 32'h7530, 1'b0);
        brake_power_i <= 16'h0028;
        cycles(3);
        check({31'h0, brake_fault_o}, 32'h0);
        brake_power_i <= 16'h0029;
        fault_reset_i <= 1'b1;
        cycles(2);
        check({30'h0, brake_fault_o, power_stage_disable_o}, 32'h3);
        brake_power_i <= 16'h0000;
        cycles(1);
        fault_reset_i <= 1'b0;
        cycles(2);
        check({31'h0, brake_fault_o}, 32'h0);
        wr(EAP_ADDR_RES_SEL, 32'h1, 1'b0);
        wr(EAP_ADDR_RES_PWR, 32'h64, 1'b0);
        wr(EAP_ADDR_RES_TON, 32'h2, 1'b0);
        rd(EAP_ADDR_RES_PWR, 32'h64, 1'b0);
        wr(EAP_ADDR_RES_VAL, 32'h8000, 1'b1);
        rd(EAP_ADDR_RES_VAL, 32'h2710, 1'b0);
        brake_power_i <= 16'h0064;
        cycles(3);
        check({31'h0, brake_fault_o}, 32'h0);
        brake_power_i <= 16'h0000;
        brake_on_i <= 1'b1;
        cycles(3);
        check({31'h0, brake_fault_o}, 32'h0);
        cycles(13);
        check({30'h0, brake_fault_o, power_stage_disable_o}, 32'h3);
        brake_on_i <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_startup();
        t_single();
        t_multi();
        t_brake();
        final_report();
    end
endmodule
